/* File: prc_pkg.sv */
/*
  Constants, register map and prescaler ratio decode for the periodic realtime counter.
  Assumes a 32-bit APB slave port with byte addresses and one register per aligned word.
*/
package prc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNT          = 8'h04;
  localparam logic [7:0] OFF_MODULO         = 8'h08;
  localparam logic [7:0] OFF_EVT_STATUS     = 8'h0C;
  localparam logic [7:0] OFF_EVT_MASK       = 8'h10;

  // status_control_register field positions
  localparam int BIT_FLAG    = 7;
  localparam int BIT_CLKS_HI = 6;
  localparam int BIT_CLKS_LO = 5;
  localparam int BIT_IE      = 4;
  localparam int BIT_PS_HI   = 3;
  localparam int BIT_PS_LO   = 0;
  // event status / mask bit
  localparam int BIT_EVT_WRAP = 0;

  // clock_source_select encodings
  localparam logic [1:0] CLKS_LPO = 2'h0;
  localparam logic [1:0] CLKS_EXT = 2'h1;

  // reset values
  localparam logic [7:0]  RST_COUNT  = 8'h00;
  localparam logic [7:0]  RST_MODULO = 8'h00;
  localparam logic [1:0]  RST_CLKS   = 2'h0;
  localparam logic [3:0]  RST_PS     = 4'h0;
  localparam logic [17:0] RST_PSC    = 18'h00000;
  localparam logic [3:0]  PS_OFF     = 4'h0;

  typedef enum logic [0:0] {APB_IDLE, APB_ACK} prc_apb_t;

  // prescaler divide ratio; hi selects the upper range
  function automatic logic [17:0] prc_divide(input logic [3:0] ps, input logic hi);
    logic [17:0] r;
    r = 18'h00001;
    case ({hi, ps})
      5'h01: r = 18'h00008;
      5'h02: r = 18'h00020;
      5'h03: r = 18'h00040;
      5'h04: r = 18'h00080;
      5'h05: r = 18'h00100;
      5'h06: r = 18'h00200;
      5'h07: r = 18'h00400;
      5'h08: r = 18'h00001;
      5'h09: r = 18'h00002;
      5'h0A: r = 18'h00004;
      5'h0B: r = 18'h0000A;
      5'h0C: r = 18'h00010;
      5'h0D: r = 18'h00064;
      5'h0E: r = 18'h001F4;
      5'h0F: r = 18'h003E8;
      5'h11: r = 18'h00400;
      5'h12: r = 18'h00800;
      5'h13: r = 18'h01000;
      5'h14: r = 18'h02000;
      5'h15: r = 18'h04000;
      5'h16: r = 18'h08000;
      5'h17: r = 18'h10000;
      5'h18: r = 18'h003E8;
      5'h19: r = 18'h007D0;
      5'h1A: r = 18'h01388;
      5'h1B: r = 18'h02710;
      5'h1C: r = 18'h04E20;
      5'h1D: r = 18'h0C350;
      5'h1E: r = 18'h186A0;
      5'h1F: r = 18'h30D40;
      default: r = 18'h00001;
    endcase
    return r;
  endfunction
endpackage

/* File: prc_counter.sv */
/*
  Periodic realtime counter: source select, binary/decimal prescaler, 8-bit modulo
  up-counter, wrap flag and interrupt, APB register slave.
  Assumes three clock source inputs sampled by sys_clk, each well below half its rate.
*/
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module prc_counter #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,    // bus clock, 10 MHz
  input  wire logic              rst_n,      // async reset, active low
  input  wire logic              psel,       // apb select
  input  wire logic              penable,    // apb access phase
  input  wire logic              pwrite,     // apb direction
  input  wire logic [ADDR_W-1:0] paddr,      // apb byte address
  input  wire logic [31:0]       pwdata,     // apb write data
  output logic      [31:0]       prdata,     // apb read data
  output logic                   pready,     // apb ready
  output logic                   pslverr,    // apb error, unmapped address
  input  wire logic              low_power_oscillator_clock, // 1 kHz source
  input  wire logic              external_reference_clock,   // external source
  input  wire logic              internal_reference_clock,   // internal source
  input  wire logic              dbg_halt,   // background debug active
  output logic                   irq         // level interrupt
);
  prc_pkg::prc_apb_t apb_r, apb_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        irq_r, irq_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic [7:0]  mod_r, mod_nxt;
  logic [17:0] psc_r, psc_nxt;
  logic [1:0]  clks_r, clks_nxt;
  logic [3:0]  ps_r, ps_nxt;
  logic        ie_r, ie_nxt;
  logic        flag_r, flag_nxt;
  logic        evt_r, evt_nxt;
  logic        emask_r, emask_nxt;
  logic [2:0]  src_raw;
  logic [2:0]  src_meta_r, src_sync_r, src_prev_r;
  logic [2:0]  src_edge;
  logic        sel_edge;
  logic [17:0] div;
  logic        psc_tick;
  logic        cfg_clr;
  logic        wrap;
  logic        xfer, wr, rd;
  logic        hit_sc, hit_cnt, hit_mod, hit_evt, hit_msk, mapped;

  // true when the low address byte selects one register word
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    return (a == off);
  endfunction

  // address decode
  assign hit_sc  = addr_is(paddr[7:0], prc_pkg::OFF_STATUS_CONTROL);
  assign hit_cnt = addr_is(paddr[7:0], prc_pkg::OFF_COUNT);
  assign hit_mod = addr_is(paddr[7:0], prc_pkg::OFF_MODULO);
  assign hit_evt = addr_is(paddr[7:0], prc_pkg::OFF_EVT_STATUS);
  assign hit_msk = addr_is(paddr[7:0], prc_pkg::OFF_EVT_MASK);
  assign mapped  = hit_sc | hit_cnt | hit_mod | hit_evt | hit_msk;
  // transfer completes at the edge that sees pready high
  assign xfer = psel & penable & pready_r;
  assign wr   = xfer & pwrite & mapped;
  // read side effects at the edge that samples the data, so a same-edge event is kept
  assign rd   = psel & penable & ~pwrite & mapped & (apb_r == prc_pkg::APB_IDLE);

  // one two-stage synchroniser and edge detector per source
  assign src_raw = {internal_reference_clock, external_reference_clock, low_power_oscillator_clock};
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        src_meta_r[g] <= 1'b0;
        src_sync_r[g] <= 1'b0;
        src_prev_r[g] <= 1'b0;
      end else begin
        src_meta_r[g] <= src_raw[g];
        src_sync_r[g] <= src_meta_r[g];
        src_prev_r[g] <= src_sync_r[g];
      end
    end
  end

  // source edge detect after two-stage synchroniser
  assign src_edge = src_sync_r & ~src_prev_r;

  always_comb begin
    case (clks_r)
      prc_pkg::CLKS_LPO: sel_edge = src_edge[0];
      prc_pkg::CLKS_EXT: sel_edge = src_edge[1];
      default:           sel_edge = src_edge[2];
    endcase
  end

  assign div = prc_pkg::prc_divide(ps_r, clks_r[0]);

  // config writes that restart the prescaler and count
  assign cfg_clr = (wr & hit_mod)
                 | (wr & hit_sc & ((pwdata[prc_pkg::BIT_CLKS_HI:prc_pkg::BIT_CLKS_LO] != clks_r)
                                 | (pwdata[prc_pkg::BIT_PS_HI:prc_pkg::BIT_PS_LO] != ps_r)));

  // one prescaler output event; frozen under debug and off while select is zero
  assign psc_tick = (ps_r != prc_pkg::PS_OFF) & ~dbg_halt & sel_edge & (psc_r == div - 18'h00001) & ~cfg_clr;
  assign wrap     = psc_tick & (cnt_r == mod_r);

  // prescaler and counter
  always_comb begin
    psc_nxt = psc_r;
    cnt_nxt = cnt_r;
    if (cfg_clr) begin
      psc_nxt = prc_pkg::RST_PSC;
      cnt_nxt = prc_pkg::RST_COUNT;
    end else if (ps_r == prc_pkg::PS_OFF) begin
      psc_nxt = prc_pkg::RST_PSC;
    end else if (!dbg_halt && sel_edge) begin
      if (psc_tick) begin
        psc_nxt = prc_pkg::RST_PSC;
        if (wrap) begin
          cnt_nxt = prc_pkg::RST_COUNT;
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end else begin
        psc_nxt = psc_r + 18'h00001;
      end
    end
  end

  // software registers and flags
  always_comb begin
    mod_nxt   = mod_r;
    clks_nxt  = clks_r;
    ps_nxt    = ps_r;
    ie_nxt    = ie_r;
    flag_nxt  = flag_r;
    evt_nxt   = evt_r;
    emask_nxt = emask_r;
    if (wr && hit_mod) begin
      mod_nxt = pwdata[7:0];
    end
    if (wr && hit_sc) begin
      clks_nxt = pwdata[prc_pkg::BIT_CLKS_HI:prc_pkg::BIT_CLKS_LO];
      ps_nxt   = pwdata[prc_pkg::BIT_PS_HI:prc_pkg::BIT_PS_LO];
      ie_nxt   = pwdata[prc_pkg::BIT_IE];
      if (pwdata[prc_pkg::BIT_FLAG]) begin
        flag_nxt = 1'b0;
      end
    end
    if (wr && hit_msk) begin
      emask_nxt = pwdata[prc_pkg::BIT_EVT_WRAP];
    end
    if (rd && hit_evt) begin
      evt_nxt = 1'b0;
    end
    // hardware set wins over a simultaneous clear
    if (wrap) begin
      flag_nxt = 1'b1;
      evt_nxt  = 1'b1;
    end
    irq_nxt = (flag_r & ie_r) | (evt_r & emask_r);
  end

  // apb slave: one wait cycle, then ready
  always_comb begin
    apb_nxt     = apb_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    case (apb_r)
      prc_pkg::APB_IDLE: begin
        if (psel && penable) begin
          apb_nxt     = prc_pkg::APB_ACK;
          pready_nxt  = 1'b1;
          pslverr_nxt = ~mapped;
          prdata_nxt  = 32'h00000000;
          if (!pwrite) begin
            if (hit_sc) begin
              prdata_nxt[7:0] = {flag_r, clks_r, ie_r, ps_r};
            end else if (hit_cnt) begin
              prdata_nxt[7:0] = cnt_r;
            end else if (hit_mod) begin
              prdata_nxt[7:0] = mod_r;
            end else if (hit_evt) begin
              prdata_nxt[0] = evt_r;
            end else if (hit_msk) begin
              prdata_nxt[0] = emask_r;
            end
          end
        end
      end
      prc_pkg::APB_ACK: begin
        apb_nxt = prc_pkg::APB_IDLE;
      end
      default: begin
        apb_nxt = prc_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      apb_r      <= prc_pkg::APB_IDLE;
      prdata_r   <= 32'h00000000;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      irq_r      <= 1'b0;
      cnt_r      <= prc_pkg::RST_COUNT;
      mod_r      <= prc_pkg::RST_MODULO;
      psc_r      <= prc_pkg::RST_PSC;
      clks_r     <= prc_pkg::RST_CLKS;
      ps_r       <= prc_pkg::RST_PS;
      ie_r       <= 1'b0;
      flag_r     <= 1'b0;
      evt_r      <= 1'b0;
      emask_r    <= 1'b0;
    end else begin
      apb_r      <= apb_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      irq_r      <= irq_nxt;
      cnt_r      <= cnt_nxt;
      mod_r      <= mod_nxt;
      psc_r      <= psc_nxt;
      clks_r     <= clks_nxt;
      ps_r       <= ps_nxt;
      ie_r       <= ie_nxt;
      flag_r     <= flag_nxt;
      evt_r      <= evt_nxt;
      emask_r    <= emask_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

  // checks
  AST_CNT_RO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr && hit_cnt && !psc_tick) |=> (cnt_r == $past(cnt_r)))
    else $error("count changed by a write");
  AST_MOD_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr && hit_mod) |=> (cnt_r == 8'h00 && psc_r == 18'h00000 && mod_r == $past(pwdata[7:0])))
    else $error("modulo write did not restart");
  AST_CFG_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr && hit_sc && pwdata[3:0] != ps_r) |=> (cnt_r == 8'h00 && psc_r == 18'h00000))
    else $error("prescaler change did not clear");
  AST_SRC_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr && hit_sc && pwdata[6:5] != clks_r) |=> (cnt_r == 8'h00 && clks_r == $past(pwdata[6:5])))
    else $error("source change did not clear");
  AST_PS_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ps_r == 4'h0) |-> (!psc_tick ##1 psc_r == 18'h00000))
    else $error("prescaler ran while off");
  AST_MOD0_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (psc_tick && mod_r == 8'h00) |=> (flag_r && cnt_r == 8'h00))
    else $error("zero modulo did not flag");
  AST_WRAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (psc_tick && cnt_r == mod_r) |=> (cnt_r == 8'h00 && flag_r))
    else $error("wrap did not flag");
  AST_NO_EARLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (psc_tick && cnt_r != mod_r && !flag_r && !(wr && hit_sc)) |=> (!flag_r && cnt_r == $past(cnt_r) + 8'h01))
    else $error("bad increment or early flag");
  AST_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (flag_r && ie_r) |-> ##1 irq_r)
    else $error("irq not raised");
  AST_W1C: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr && hit_sc && pwdata[7] && !wrap) |=> !flag_r ##1 (!irq_r || $past(evt_r && emask_r)))
    else $error("flag not cleared by one");
  AST_W0: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr && hit_sc && !pwdata[7] && flag_r) |=> flag_r)
    else $error("zero write cleared flag");
  AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dbg_halt && !cfg_clr) |=> ($stable(cnt_r) && $stable(psc_r)))
    else $error("count moved in debug halt");
  AST_READY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (psel && penable && !pready_r) |=> pready_r)
    else $error("apb ready late");

  COV_WRAP: cover property (@(posedge sys_clk) disable iff (!rst_n) wrap && mod_r != 8'h00);
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(irq_r));
  COV_FREEZE: cover property (@(posedge sys_clk) disable iff (!rst_n) dbg_halt && sel_edge && ps_r != 4'h0);
  COV_MODW: cover property (@(posedge sys_clk) disable iff (!rst_n) wr && hit_mod && cnt_r != 8'h00);
  COV_SLVERR: cover property (@(posedge sys_clk) disable iff (!rst_n) pready_r && pslverr_r);

  // flag and event bits, interrupt
  AST_EVT_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrap
    |=> evt_r)
    else $error("wrap did not set event bit");
  AST_EVT_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd && hit_evt && !wrap)
    |=> !evt_r)
    else $error("event bit not cleared by read");
  AST_FLAG_SRC: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!flag_r && !wrap)
    |=> !flag_r)
    else $error("flag set without a wrap");
  AST_FLAG_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (flag_r && !(wr && hit_sc && pwdata[7]))
    |=> flag_r)
    else $error("flag lost without a clearing write");
  AST_IRQ_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!(flag_r && ie_r) && !(evt_r && emask_r))
    |=> !irq_r)
    else $error("irq raised with nothing pending");

  // counter and prescaler
  AST_CNT_LE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1
    |-> (cnt_r <= mod_r))
    else $error("count above modulo");
  AST_DIV_BOUND: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1
    |-> (psc_r < div))
    else $error("prescaler beyond its ratio");
  AST_TICK_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    psc_tick
    |=> (psc_r == 18'h00000))
    else $error("prescaler not restarted after event");
  AST_HALT_NO_TICK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dbg_halt
    |-> !psc_tick)
    else $error("prescaler event during debug halt");
  AST_SRC_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!cfg_clr && !sel_edge)
    |=> ($stable(psc_r) && $stable(cnt_r)))
    else $error("counting without a source edge");
  AST_SAME_CFG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr && hit_sc && pwdata[6:5] == clks_r && pwdata[3:0] == ps_r && !psc_tick)
    |=> $stable(cnt_r))
    else $error("unchanged select cleared the count");
  AST_MOD_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(wr && hit_mod)
    |=> $stable(mod_r))
    else $error("modulo changed without a write");

  // bus slave
  AST_READY_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pready_r
    |=> !pready_r)
    else $error("ready held longer than one cycle");
  AST_SLVERR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (psel && penable && apb_r == prc_pkg::APB_IDLE && !mapped)
    |=> (pready_r && pslverr_r))
    else $error("unmapped access not flagged");
  AST_SLVERR_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pslverr_r
    |-> pready_r)
    else $error("error shown without ready");
  AST_SLVERR_MAPPED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (psel && penable && apb_r == prc_pkg::APB_IDLE && mapped)
    |=> !pslverr_r)
    else $error("error on a mapped access");
endmodule

/* File: test_periodic_realtime_counter.sv */
/*
  Bench for prc_counter: APB register checks, divide ratios, wrap flag, interrupts, restarts.
  Assumes prc_pkg is compiled first; the bench drives all three clock sources itself.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); end end
module test_periodic_realtime_counter;
  localparam logic [7:0] SC = prc_pkg::OFF_STATUS_CONTROL;
  localparam logic [7:0] CN = prc_pkg::OFF_COUNT;
  localparam logic [7:0] MD = prc_pkg::OFF_MODULO;
  localparam logic [7:0] EV = prc_pkg::OFF_EVT_STATUS;
  localparam logic [7:0] MK = prc_pkg::OFF_EVT_MASK;
  logic        sys_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lpo_clk   = 1'b0;
  logic        ext_clk   = 1'b0;
  logic        int_clk   = 1'b0;
  logic        dbg_halt  = 1'b0;
  logic        irq;
  logic [31:0] rdv;
  logic        rerr;
  int          err_count = 0;
  int          n_checks  = 0;
  int          cyc       = 0;
  int          t0;
  int          dv[18]    = '{8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000, 1, 1024, 1000};
  logic [7:0]  xs[3]     = '{8'h48, 8'h21, 8'h68};

  prc_counter uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_power_oscillator_clock(lpo_clk), .external_reference_clock(ext_clk),
    .internal_reference_clock(int_clk), .dbg_halt(dbg_halt), .irq(irq)
  );

  always #50 sys_clk = ~sys_clk;

  // source periods of 6, 8 and 10 bus cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    lpo_clk <= (cyc % 6) < 3;
    ext_clk <= (cyc % 8) < 4;
    int_clk <= (cyc % 10) < 5;
    if (cyc == 80000) begin
      err_count++;
      give_verdict();
    end
  end

  function automatic int pp(input int i);
    return (i < 15) ? 6 : ((i == 16) ? 8 : 10);
  endfunction

  task automatic give_verdict();
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rdv, {24'h000000, e})
  endtask

  // poll the count until it shows v, never above lim
  task automatic wait_cnt(input logic [7:0] v, input logic [7:0] lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, CN, 8'h00);
      `CHK(rdv[7:0] <= lim, 1'b1)
      n++;
    end while (rdv[7:0] !== v && n < 3000);
    `CHK(rdv[7:0], v)
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(SC, 8'h00);
    rchk(CN, 8'h00);
    rchk(MD, 8'h00);
    rchk(EV, 8'h00);
    rchk(MK, 8'h00);
    apb(1'b1, 8'h14, 8'h5A);
    `CHK(rerr, 1'b1)
    apb(1'b1, MD, 8'hFF);
    rchk(MD, 8'hFF);
    apb(1'b1, CN, 8'h55);
    `CHK(rerr, 1'b0)
    rchk(CN, 8'h00);
    repeat (300) @(posedge sys_clk);
    rchk(CN, 8'h00);
    // every code of the low range, then the other sources and the high range
    for (int i = 0; i < 18; i++) begin
      apb(1'b1, SC, (i < 15) ? 8'(i + 1) : xs[i - 15]);
      t0 = cyc;
      do apb(1'b0, CN, 8'h00); while (rdv[7:0] === 8'h00 && cyc - t0 < 20000);
      `CHK((cyc - t0) >= dv[i] * pp(i) - pp(i) && (cyc - t0) <= dv[i] * pp(i) + 10, 1'b1)
    end
    apb(1'b1, MD, 8'h03);
    apb(1'b1, SC, 8'h0B);
    wait_cnt(8'h03, 8'h03);
    rchk(SC, 8'h0B);
    wait_cnt(8'h00, 8'h03);
    rchk(SC, 8'h8B);
    `CHK(irq, 1'b0)
    apb(1'b1, SC, 8'h1B);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    rchk(SC, 8'h9B);
    apb(1'b1, SC, 8'h9B);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    rchk(SC, 8'h1B);
    rchk(EV, 8'h01);
    rchk(EV, 8'h00);
    apb(1'b1, SC, 8'h0B);
    apb(1'b1, MK, 8'h01);
    wait_cnt(8'h02, 8'h03);
    wait_cnt(8'h00, 8'h03);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    rchk(EV, 8'h01);
    // restarts: modulo write, prescaler change, source change, unchanged rewrite
    wait_cnt(8'h02, 8'h03);
    apb(1'b1, MD, 8'h03);
    rchk(CN, 8'h00);
    wait_cnt(8'h01, 8'h03);
    apb(1'b1, SC, 8'h0C);
    rchk(CN, 8'h00);
    wait_cnt(8'h01, 8'h03);
    apb(1'b1, SC, 8'h4C);
    rchk(CN, 8'h00);
    wait_cnt(8'h01, 8'h03);
    apb(1'b1, SC, 8'h4C);
    rchk(CN, 8'h01);
    wait_cnt(8'h02, 8'h03);
    dbg_halt <= 1'b1;
    repeat (400) @(posedge sys_clk);
    rchk(CN, 8'h02);
    dbg_halt <= 1'b0;
    wait_cnt(8'h03, 8'h03);
    apb(1'b1, MD, 8'h00);
    apb(1'b1, SC, 8'hC8);
    repeat (30) @(posedge sys_clk);
    rchk(SC, 8'hC8);
    rchk(CN, 8'h00);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    rst_n <= 1'b1;
    rchk(SC, 8'h00);
    rchk(MD, 8'h00);
    repeat (100) @(posedge sys_clk);
    rchk(CN, 8'h00);
    give_verdict();
  end
endmodule
